/* File: rtl/ibs_pkg.sv */
// Shared constants and types for the isolation barrier sync control link.
package ibs_pkg;
    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_POWER = 8'h02;
    localparam logic [7:0] IDX_BARRIER_SYNC_LOSS_FLAG = 8'h03;
    localparam logic [7:0] IDX_IRQCFG = 8'h05;
    localparam logic [7:0] IDX_BARCTL = 8'h0D;
    localparam logic [7:0] IDX_NTR = 8'h15;
    localparam logic [7:0] IDX_LINEID = 8'h1D;
    localparam logic [7:0] IDX_LINESTAT = 8'h1E;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_LINE_POWER = 2;
    localparam int BIT_LEVEL_DETECT = 3;
    localparam int BIT_BARRIER_SYNC_LOSS_FLAG = 1;
    localparam int BIT_IRQ_EN = 1;
    localparam int BIT_AUTO_POLL = 3;
    localparam int BIT_LINE_RESET = 3;
    localparam int BIT_HOST_LOST = 6;
    localparam int BIT_NTR_DISABLE = 6;
    localparam int BIT_ID_LSB = 4;
    localparam int BIT_LINE_LOST = 2;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic RST_LINE_POWER = 1'b0;
    localparam logic RST_IRQ_EN = 1'b1;
    localparam logic RST_AUTO_POLL = 1'b1;
    localparam logic RST_NTR_DISABLE = 1'b0;
    localparam logic [3:0] RST_LINE_ID = 4'h0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 100;
    localparam int NTR_TIME_US = 400;
    localparam int NTR_CYCLES = NTR_TIME_US * CLOCK_MHZ;
    localparam int STATUS_PERIOD = 16;
    localparam int SYNC_TIMEOUT = 64;
    localparam int LOCK_PREAMBLES = 4;
    // ------------------------------------------------------------
    // Frame kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        HK_PREAMBLE = 2'b00,
        HK_POLL = 2'b01,
        HK_DATA = 2'b10,
        HK_RESET = 2'b11
    } ibs_hkind_t;
    typedef enum logic [1:0] {
        LK_STATUS = 2'b00,
        LK_ID = 2'b01,
        LK_RXDATA = 2'b10,
        LK_SPARE = 2'b11
    } ibs_lkind_t;
    // Loop operating modes on the line side.
    typedef enum logic [1:0] {
        LM_OFF = 2'b00,
        LM_HOLD = 2'b01,
        LM_SEIZE = 2'b10,
        LM_OTHER = 2'b11
    } ibs_loop_t;
    // Even parity over a frame header and payload.
    function automatic logic ibs_parity(input logic [1:0] kind, input logic [7:0] word);
        return ^{kind, word};
    endfunction : ibs_parity
endpackage : ibs_pkg

/* File: rtl/ibs_link_if.sv */
// Barrier link between the host-side end and the line-side end.
`timescale 1ns/1ps
interface ibs_link_if;
    import ibs_pkg::*;
    // Host to line.
    logic [1:0] hl_kind;
    logic [7:0] hl_word;
    logic hl_parity;
    logic hl_strobe;
    logic hl_power;
    logic hl_ntr_disable;
    // Line to host.
    logic [1:0] lh_kind;
    logic [7:0] lh_word;
    logic lh_parity;
    logic lh_strobe;
    modport host_end (
        output hl_kind, hl_word, hl_parity, hl_strobe, hl_power, hl_ntr_disable,
        input lh_kind, lh_word, lh_parity, lh_strobe
    );
    modport line_end (
        input hl_kind, hl_word, hl_parity, hl_strobe, hl_power, hl_ntr_disable,
        output lh_kind, lh_word, lh_parity, lh_strobe
    );
endinterface : ibs_link_if

/* File: rtl/ibs_line_end.sv */
// Line-side end: lock, identifier reply, status stream, watchdog and hook control.
`timescale 1ns/1ps
module ibs_line_end #(
    parameter int NTR_LIMIT = ibs_pkg::NTR_CYCLES,
    parameter logic [3:0] LINE_ID = 4'hA // Arbitrary identifier value.
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Barrier
    ibs_link_if.line_end link,
    // Line user side
    input wire logic offhook_req,
    input wire logic ac_loop_enable,
    input wire logic dc_loop_enable,
    input wire logic [1:0] dc_loop_characteristic,
    input wire logic supply_low,
    input wire logic [7:0] rx_sample,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [7:0] tx_sample,
    output logic tx_sample_valid,
    output logic off_hook,
    output ibs_pkg::ibs_loop_t loop_mode,
    output logic [1:0] dc_char_applied,
    output logic transmit_ready_pulse
);
    import ibs_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        L_UNLOCK = 2'b00,
        L_LOCKED = 2'b01,
        L_SYNC = 2'b10
    } ibs_lstate_t;
    ibs_lstate_t state_reg, state_next;
    logic [2:0] pre_cnt_reg;
    logic [15:0] ntr_cnt_reg;
    logic [3:0] tick_cnt_reg;
    logic id_pend_reg;
    logic line_sync_lost_flag_reg;

    // Decoded receive events.
    wire hl_ok = link.hl_strobe && (ibs_parity(link.hl_kind, link.hl_word) == link.hl_parity);
    wire hl_perr = link.hl_strobe && !hl_ok;
    wire got_pre = hl_ok && (link.hl_kind == HK_PREAMBLE);
    wire got_poll = hl_ok && (link.hl_kind == HK_POLL);
    wire got_data = hl_ok && (link.hl_kind == HK_DATA);
    wire got_reset = hl_ok && (link.hl_kind == HK_RESET);
    wire locked = state_reg != L_UNLOCK;
    wire transition = link.hl_strobe || link.hl_power;
    wire ntr_expire = !link.hl_ntr_disable && (ntr_cnt_reg == 16'(NTR_LIMIT - 1));
    wire tick = tick_cnt_reg == 4'(STATUS_PERIOD - 1);
    // Status goes out on every tick while locked unless an ID reply is pending, so the flag rides along automatically.
    assign transmit_ready_pulse = tick && locked;
    wire send_id = id_pend_reg;
    wire send_stat = !send_id && transmit_ready_pulse;
    assign rx_ready = !send_id && !send_stat && (state_reg == L_SYNC);
    wire send_rx = rx_ready && rx_valid;

    // Sync state: a header error or watchdog expiry drops the lock.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            L_UNLOCK: if (got_pre && pre_cnt_reg == 3'(LOCK_PREAMBLES - 1)) state_next = L_LOCKED;
            L_LOCKED: if (got_poll || got_data) state_next = L_SYNC;
            L_SYNC: state_next = L_SYNC;
        endcase
        if (hl_perr || got_reset || ntr_expire) state_next = L_UNLOCK;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= L_UNLOCK;
            pre_cnt_reg <= 3'h0;
            ntr_cnt_reg <= 16'h0;
            tick_cnt_reg <= 4'h0;
            id_pend_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next != L_UNLOCK) pre_cnt_reg <= 3'h0;
            else if (got_pre) pre_cnt_reg <= pre_cnt_reg + 3'h1;
            ntr_cnt_reg <= (transition || ntr_expire) ? 16'h0 : ntr_cnt_reg + 16'h1;
            tick_cnt_reg <= tick ? 4'h0 : tick_cnt_reg + 4'h1;
            if (state_next == L_UNLOCK) id_pend_reg <= 1'b0;
            else if (got_poll) id_pend_reg <= 1'b1;
            else if (send_id) id_pend_reg <= 1'b0;
        end
    end

    // Header errors set the flag; sending it in a status frame clears it, set wins.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_sync_lost_flag_reg <= 1'b0;
        end else if (hl_perr) begin
            line_sync_lost_flag_reg <= 1'b1;
        end else if (send_stat || got_reset) begin
            line_sync_lost_flag_reg <= 1'b0;
        end
    end

    // Frames toward the host.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.lh_strobe <= 1'b0;
            link.lh_kind <= LK_STATUS;
            link.lh_word <= 8'h00;
            link.lh_parity <= 1'b0;
        end else begin
            link.lh_strobe <= send_id || send_stat || send_rx;
            if (send_id) begin
                link.lh_kind <= LK_ID;
                link.lh_word <= {4'h0, LINE_ID};
                link.lh_parity <= ibs_parity(LK_ID, {4'h0, LINE_ID});
            end else if (send_stat) begin
                link.lh_kind <= LK_STATUS;
                link.lh_word <= 8'(line_sync_lost_flag_reg) << BIT_LINE_LOST;
                link.lh_parity <= ibs_parity(LK_STATUS, 8'(line_sync_lost_flag_reg) << BIT_LINE_LOST);
            end else if (send_rx) begin
                link.lh_kind <= LK_RXDATA;
                link.lh_word <= rx_sample;
                link.lh_parity <= ibs_parity(LK_RXDATA, rx_sample);
            end
        end
    end

    // Transmit samples, hook switch and loop mode; power-on reset leaves it on hook.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_sample <= 8'h00;
            tx_sample_valid <= 1'b0;
            off_hook <= 1'b0;
            loop_mode <= LM_OFF;
            dc_char_applied <= 2'h0;
        end else begin
            tx_sample_valid <= got_data && locked;
            if (got_data) tx_sample <= link.hl_word;
            off_hook <= offhook_req && !supply_low && !ntr_expire && (off_hook || locked);
            loop_mode <= !off_hook ? LM_OFF : (dc_loop_enable && ac_loop_enable) ? LM_HOLD :
                         dc_loop_enable ? LM_SEIZE : LM_OFF;
            // Seize uses its own fixed characteristic.
            dc_char_applied <= (dc_loop_enable && !ac_loop_enable) ? 2'h0 : dc_loop_characteristic;
        end
    end
endmodule : ibs_line_end

/* File: rtl/ibs_host_end.sv */
// Host-side end: APB registers, power multiplexing, sync sequencing and auto-poll.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module ibs_host_end (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [9:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transmit and receive data
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    // Interrupt
    output logic irq,
    // Barrier
    ibs_link_if.host_end link
);
    import ibs_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        H_PREAMBLE = 3'b000,
        H_POLL = 3'b001,
        H_WAIT_ID = 3'b010,
        H_DATA = 3'b011,
        H_RESET = 3'b100
    } ibs_hstate_t;
    ibs_hstate_t state_reg, state_next;
    logic phase_reg;
    logic [6:0] silence_reg;
    logic loss_active_reg;
    logic line_power_select_reg;
    logic level_detect_enable_reg;
    logic barrier_sync_loss_flag_reg;
    logic sync_loss_irq_enable_reg;
    logic auto_poll_enable_reg;
    logic line_barrier_reset_reg;
    logic host_sync_lost_flag_reg;
    logic no_transition_timer_disable_reg;
    logic [3:0] line_side_id_field_reg;
    logic line_sync_lost_flag_reg;
    logic [1:0] send_kind;
    logic [7:0] send_word;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    // Registers answer at once, so the access phase lasts one cycle.
    wire [7:0] idx = paddr[9:2];
    wire access = psel && penable;
    wire hit = (idx == IDX_POWER) || (idx == IDX_BARRIER_SYNC_LOSS_FLAG) || (idx == IDX_IRQCFG) ||
               (idx == IDX_BARCTL) || (idx == IDX_NTR) || (idx == IDX_LINEID) ||
               (idx == IDX_LINESTAT);
    wire wr = access && pwrite && hit;
    wire rd = access && !pwrite && hit;
    wire wr_power = wr && idx == IDX_POWER;
    wire wr_irqcfg = wr && idx == IDX_IRQCFG;
    wire wr_barctl = wr && idx == IDX_BARCTL;
    wire wr_ntr = wr && idx == IDX_NTR;
    wire rd_barrier_sync_loss_flag = rd && idx == IDX_BARRIER_SYNC_LOSS_FLAG;
    wire rd_barctl = rd && idx == IDX_BARCTL;
    assign pready = 1'b1;
    assign pslverr = access && !hit;

    // Read mux; the no-transition disable bit is write-only and reads zero.
    always_comb begin
        prdata = 32'h0000_0000;
        unique case (idx)
            IDX_POWER: begin
                prdata[BIT_LINE_POWER] = line_power_select_reg;
                prdata[BIT_LEVEL_DETECT] = level_detect_enable_reg;
            end
            IDX_BARRIER_SYNC_LOSS_FLAG: prdata[BIT_BARRIER_SYNC_LOSS_FLAG] = barrier_sync_loss_flag_reg;
            IDX_IRQCFG: begin
                prdata[BIT_AUTO_POLL] = auto_poll_enable_reg;
                prdata[BIT_IRQ_EN] = sync_loss_irq_enable_reg;
            end
            IDX_BARCTL: begin
                prdata[BIT_HOST_LOST] = host_sync_lost_flag_reg;
                prdata[BIT_LINE_RESET] = line_barrier_reset_reg;
            end
            IDX_LINEID: prdata[BIT_ID_LSB +: 4] = line_side_id_field_reg;
            IDX_LINESTAT: prdata[BIT_LINE_LOST] = line_sync_lost_flag_reg;
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // Link decode
    // ------------------------------------------------------------
    wire lh_ok = link.lh_strobe && (ibs_parity(link.lh_kind, link.lh_word) == link.lh_parity);
    wire lh_perr = link.lh_strobe && !lh_ok;
    wire got_status = lh_ok && link.lh_kind == LK_STATUS;
    wire got_id = lh_ok && link.lh_kind == LK_ID;
    wire synced = state_reg == H_POLL || state_reg == H_WAIT_ID || state_reg == H_DATA;
    wire slot = !phase_reg;
    // Silence beyond several status periods, or a corrupted frame, counts as loss.
    // A line-side reset drops its sync as well, so software sees it as a loss too.
    wire loss = (synced && (lh_perr || silence_reg == 7'(SYNC_TIMEOUT))) ||
                (state_reg == H_RESET && slot);
    assign tx_ready = slot && state_reg == H_DATA;
    wire send_tx = tx_ready && tx_valid;

    // Sequencer: preamble until status is seen, optional poll, then data.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            H_PREAMBLE: if (got_status) state_next = auto_poll_enable_reg ? H_POLL : H_DATA;
            H_POLL: if (slot) state_next = H_WAIT_ID;
            H_WAIT_ID: if (got_id) state_next = H_DATA;
            H_DATA: state_next = H_DATA;
            H_RESET: if (slot) state_next = H_PREAMBLE;
        endcase
        if (loss) state_next = H_PREAMBLE;
        if (line_barrier_reset_reg && state_reg != H_RESET) state_next = H_RESET;
    end

    // Outgoing frame selection; idle slots carry preambles to keep transitions alive.
    always_comb begin
        send_kind = HK_PREAMBLE;
        send_word = 8'h00;
        unique case (state_reg)
            H_POLL: send_kind = HK_POLL;
            H_RESET: send_kind = HK_RESET;
            H_DATA: if (send_tx) begin
                send_kind = HK_DATA;
                send_word = tx_data;
            end
            default: send_kind = HK_PREAMBLE;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer and link registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= H_PREAMBLE;
            phase_reg <= 1'b0;
            silence_reg <= 7'h00;
            loss_active_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            phase_reg <= !phase_reg;
            silence_reg <= (!synced || link.lh_strobe) ? 7'h00 : silence_reg + 7'h01;
            if (loss) loss_active_reg <= 1'b1;
            else if (got_status) loss_active_reg <= 1'b0;
        end
    end

    // Barrier power rides the odd phase; line-powered mode turns it off.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            link.hl_strobe <= 1'b0;
            link.hl_kind <= HK_PREAMBLE;
            link.hl_word <= 8'h00;
            link.hl_parity <= 1'b0;
            link.hl_power <= 1'b0;
            link.hl_ntr_disable <= RST_NTR_DISABLE;
        end else begin
            link.hl_strobe <= slot;
            link.hl_kind <= send_kind;
            link.hl_word <= send_word;
            link.hl_parity <= ibs_parity(send_kind, send_word);
            link.hl_power <= !slot && !line_power_select_reg;
            link.hl_ntr_disable <= no_transition_timer_disable_reg;
        end
    end

    // Receive data toward the user.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            line_side_id_field_reg <= RST_LINE_ID;
            line_sync_lost_flag_reg <= 1'b0;
        end else begin
            rx_valid <= lh_ok && link.lh_kind == LK_RXDATA && state_reg == H_DATA;
            if (lh_ok && link.lh_kind == LK_RXDATA) rx_data <= link.lh_word;
            if (loss || state_reg == H_RESET) line_side_id_field_reg <= RST_LINE_ID;
            else if (got_id && state_reg == H_WAIT_ID) line_side_id_field_reg <= link.lh_word[3:0];
            if (got_status) line_sync_lost_flag_reg <= link.lh_word[BIT_LINE_LOST];
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    // Leaving line power with level detect on is refused and the mode stays.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            line_power_select_reg <= RST_LINE_POWER;
            level_detect_enable_reg <= 1'b0;
            sync_loss_irq_enable_reg <= RST_IRQ_EN;
            auto_poll_enable_reg <= RST_AUTO_POLL;
            no_transition_timer_disable_reg <= RST_NTR_DISABLE;
        end else begin
            if (wr_power) begin
                level_detect_enable_reg <= pwdata[BIT_LEVEL_DETECT];
                if (pwdata[BIT_LINE_POWER] || !level_detect_enable_reg)
                    line_power_select_reg <= pwdata[BIT_LINE_POWER];
            end
            if (wr_irqcfg) begin
                sync_loss_irq_enable_reg <= pwdata[BIT_IRQ_EN];
                auto_poll_enable_reg <= pwdata[BIT_AUTO_POLL];
            end
            if (wr_ntr) no_transition_timer_disable_reg <= pwdata[BIT_NTR_DISABLE];
        end
    end

    // Flags: a set in the same cycle as a clearing read wins.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            barrier_sync_loss_flag_reg <= 1'b0;
            host_sync_lost_flag_reg <= 1'b0;
            line_barrier_reset_reg <= 1'b0;
        end else begin
            if (loss) barrier_sync_loss_flag_reg <= 1'b1;
            else if (rd_barrier_sync_loss_flag) barrier_sync_loss_flag_reg <= 1'b0;
            if (loss || loss_active_reg) host_sync_lost_flag_reg <= 1'b1;
            else if (rd_barctl) host_sync_lost_flag_reg <= 1'b0;
            // Self-clears once the reset frame has gone out.
            if (state_reg == H_RESET && slot) line_barrier_reset_reg <= 1'b0;
            else if (wr_barctl && pwdata[BIT_LINE_RESET]) line_barrier_reset_reg <= 1'b1;
        end
    end

    // Level interrupt, dropped when the flag is read away.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= barrier_sync_loss_flag_reg && sync_loss_irq_enable_reg;
        end
    end
endmodule : ibs_host_end

/* File: verif/ibs_link_asserts.sv */
// Concurrent checks on the barrier link between the two ends.
`timescale 1ns/1ps
// ----------
// Checker
// ----------
module ibs_link_asserts
    import ibs_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Host to line
    input wire logic [1:0] hl_kind,
    input wire logic [7:0] hl_word,
    input wire logic hl_parity,
    input wire logic hl_strobe,
    input wire logic hl_power,
    input wire logic hl_ntr_disable,
    // Line to host
    input wire logic [1:0] lh_kind,
    input wire logic [7:0] lh_word,
    input wire logic lh_parity,
    input wire logic lh_strobe
);
    logic [3:0] cyc;
    // Saturating age since reset, so early-life checks need no long counter.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) cyc <= 4'h0;
        else if (cyc != 4'hF) cyc <= cyc + 4'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    property p_slot; hl_strobe |=> !hl_strobe ##1 hl_strobe; endproperty
    a_slot: assert property (p_slot) else $error("frame slot missed");
    property p_pwr_gap; hl_power |-> !hl_strobe; endproperty
    a_pwr_gap: assert property (p_pwr_gap) else $error("power on data slot");
    property p_pwr_next; hl_power |=> hl_strobe; endproperty
    a_pwr_next: assert property (p_pwr_next) else $error("power slot order");
    property p_pwr_first; (cyc < 4'h8) && hl_strobe |=> hl_power; endproperty
    a_pwr_first: assert property (p_pwr_first) else $error("no power at start");
    property p_pre_first; (cyc < 4'h8) && hl_strobe |-> hl_kind == HK_PREAMBLE; endproperty
    a_pre_first: assert property (p_pre_first) else $error("no preamble at start");
    property p_hl_par; hl_strobe |-> hl_parity == ^{hl_kind, hl_word}; endproperty
    a_hl_par: assert property (p_hl_par) else $error("host frame parity");
    property p_lh_par; lh_strobe |-> lh_parity == ^{lh_kind, lh_word}; endproperty
    a_lh_par: assert property (p_lh_par) else $error("line frame parity");
    property p_id; hl_strobe && hl_kind == HK_POLL |-> ##2 lh_strobe && lh_kind == LK_ID; endproperty
    a_id: assert property (p_id) else $error("poll not answered");
    // Main traffic kinds seen on the wire.
    c_poll: cover property (hl_strobe && hl_kind == HK_POLL);
    c_reset: cover property (hl_strobe && hl_kind == HK_RESET);
    c_rx: cover property (lh_strobe && lh_kind == LK_RXDATA);
endmodule : ibs_link_asserts

/* File: verif/tb_top.sv */
// Bench for both barrier ends joined by the link.
`timescale 1ns/1ps
module tb_top;
    import ibs_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hook = 1'b0, ac = 1'b0, dc = 1'b0;
    logic low = 1'b0, pready, pslverr, irq, off_hook;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [1:0] dca, dcv = 2'h2;
    logic [7:0] txs, rxd;
    ibs_loop_t loop_mode;
    int n_fail = 0, total_checks = 0, cycles = 0;
    ibs_link_if link();
    always #5 clock = ~clock;
    ibs_host_end u_ibs_host_end (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .tx_data(8'hC3), .tx_valid(1'b1), .tx_ready(), .rx_data(rxd),
        .rx_valid(), .irq(irq), .link(link));
    ibs_line_end #(.NTR_LIMIT(200)) u_ibs_line_end (.clock(clock), .rst(rst), .link(link),
        .offhook_req(hook), .ac_loop_enable(ac), .dc_loop_enable(dc),
        .dc_loop_characteristic(dcv), .supply_low(low), .rx_sample(8'h5A), .rx_valid(1'b1),
        .rx_ready(), .tx_sample(txs), .tx_sample_valid(), .off_hook(off_hook),
        .loop_mode(loop_mode), .dc_char_applied(dca), .transmit_ready_pulse());
    ibs_link_asserts u_ibs_link_asserts (.clock(clock), .rst(rst), .hl_kind(link.hl_kind),
        .hl_word(link.hl_word), .hl_parity(link.hl_parity), .hl_strobe(link.hl_strobe),
        .hl_power(link.hl_power), .hl_ntr_disable(link.hl_ntr_disable),
        .lh_kind(link.lh_kind), .lh_word(link.lh_word), .lh_parity(link.lh_parity),
        .lh_strobe(link.lh_strobe));
    // ----------
    // Helpers
    // ----------
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        total_checks++;
        if (g !== x) begin
            n_fail++;
            $display("BAD %0t got %h want %h", $time, g, x);
        end
    endtask : chk
    // Read data is taken at the edge that completes the access, before a read-clear lands.
    task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'h0};
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, i, d, r, e);
    endtask : wr
    task automatic rd(input logic [7:0] i, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, i, 32'h0, r, e);
        chk(r, x);
    endtask : rd
    task automatic wait_id(input logic [3:0] x);
        logic [31:0] r;
        logic e;
        repeat (80) begin
            apb(1'b0, IDX_LINEID, 32'h0, r, e);
            if (r[7:4] === x) break;
        end
        chk(r, {24'h0, x, 4'h0});
    endtask : wait_id
    task automatic settle(input int n);
        repeat (n) @(negedge clock);
    endtask : settle
    // ----------
    // Scenarios
    // ----------
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        rd(IDX_POWER, 32'h0);
        rd(IDX_IRQCFG, 32'hA);
        rd(IDX_LINESTAT, 32'h0);
        apb(1'b0, 8'h01, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        wait_id(4'hA);
        settle(4);
        chk({24'h0, txs}, 32'hC3);
        chk({24'h0, rxd}, 32'h5A);
        rd(IDX_BARRIER_SYNC_LOSS_FLAG, 32'h0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_loss(input logic [31:0] cfg);
        wr(IDX_IRQCFG, cfg);
        wr(IDX_BARCTL, 32'h8);
        for (int n = 0; n < 300 && irq !== 1'b1; n++) @(negedge clock);
        if (cfg[1]) rd(IDX_LINEID, 32'h0);
        else settle(200);
        chk({31'h0, irq}, {31'h0, cfg[1]});
        rd(IDX_BARRIER_SYNC_LOSS_FLAG, 32'h2);
        settle(3);
        chk({31'h0, irq}, 32'h0);
        if (cfg[3]) wait_id(4'hA);
        else begin
            settle(60);
            rd(IDX_LINEID, 32'h0);
        end
        wr(IDX_IRQCFG, 32'hA);
        rd(IDX_BARCTL, 32'h40);
        rd(IDX_BARCTL, 32'h0);
        $display("t_loss done");
    endtask : t_loss
    task automatic t_power();
        int n = 0;
        wr(IDX_POWER, 32'h4);
        rd(IDX_POWER, 32'h4);
        repeat (20) begin
            @(negedge clock);
            if (link.hl_power !== 1'b0) n++;
        end
        chk(n, 0);
        wr(IDX_POWER, 32'hC);
        wr(IDX_POWER, 32'h8);
        rd(IDX_POWER, 32'hC);
        wr(IDX_POWER, 32'h4);
        wr(IDX_POWER, 32'h0);
        rd(IDX_POWER, 32'h0);
        $display("t_power done");
    endtask : t_power
    task automatic t_hook();
        @(posedge clock);
        hook <= 1'b1;
        ac <= 1'b1;
        dc <= 1'b1;
        settle(10);
        chk({31'h0, off_hook}, 32'h1);
        chk({28'h0, loop_mode, dca}, {28'h0, LM_HOLD, dcv});
        @(posedge clock);
        ac <= 1'b0;
        settle(10);
        chk({28'h0, loop_mode, dca}, {28'h0, LM_SEIZE, 2'h0});
        @(posedge clock);
        low <= 1'b1;
        settle(10);
        chk({31'h0, off_hook}, 32'h0);
        $display("t_hook done");
    endtask : t_hook
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    // A hang anywhere is cut short here and reported as a mismatch.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end
    // Main sequence.
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_loss(32'hA);
        t_loss(32'h8);
        t_power();
        t_hook();
        t_loss(32'h2);
        conclude();
    end
endmodule : tb_top
